// ===== hw/sram_input_port.sv
// SRAM end: input registers, burst address counter and write lane enables
`timescale 1ns/100ps
`include "sram_port_params.svh"
module sram_input_port (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    // Pins from the controller
    sram_port_if.device              pins,
    // Core side
    output sram_port_pkg::addr_t     access_address,
    output logic                     access_valid,
    output logic                     access_write,
    output sram_port_pkg::lane_sel_t lane_write_enable,
    output sram_port_pkg::data_t     access_data,
    output sram_port_pkg::parity_t   access_parity
);
    import sram_port_pkg::*;

    // Pins share ref_clk with the controller, so they are sampled directly
    addr_t     base_addr;
    addr_t     next_base_addr;
    logic [`BURST_W-1:0] burst_cnt;
    logic [`BURST_W-1:0] next_burst_cnt;
    logic      valid_q;
    logic      next_valid_q;
    logic      write_q;
    logic      next_write_q;
    lane_sel_t lane_q;
    lane_sel_t next_lane_q;
    data_t     data_q;
    data_t     next_data_q;
    parity_t   parity_q;
    parity_t   next_parity_q;

    always_comb begin
        next_base_addr = base_addr;
        next_burst_cnt = burst_cnt;
        next_valid_q   = valid_q;
        next_write_q   = write_q;
        next_lane_q    = lane_q;
        next_data_q    = data_q;
        next_parity_q  = parity_q;
        if (!pins.clock_qualify_n) begin
            next_valid_q  = 1'b1;
            next_write_q  = ~pins.write_strobe_n;
            next_lane_q   = pins.lane_write_select_n;
            next_data_q   = pins.write_data;
            next_parity_q = pins.parity_lane;
            if (pins.advance_or_load) begin
                // Linear order, wraps inside the burst group
                next_burst_cnt = burst_cnt + `BURST_ONE;
            end else begin
                next_base_addr = pins.address;
                next_burst_cnt = `BURST_ZERO;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_addr <= `ADDR_ZERO;
            burst_cnt <= `BURST_ZERO;
            valid_q   <= 1'b0;
            write_q   <= 1'b0;
            lane_q    <= `LANES_OFF;
            data_q    <= '0;
            parity_q  <= '0;
        end else begin
            base_addr <= next_base_addr;
            burst_cnt <= next_burst_cnt;
            valid_q   <= next_valid_q;
            write_q   <= next_write_q;
            lane_q    <= next_lane_q;
            data_q    <= next_data_q;
            parity_q  <= next_parity_q;
        end
    end

    // Only the low address bits take part in the burst
    assign access_address = {base_addr[`ADDR_W-1:`BURST_W], base_addr[`BURST_W-1:0] + burst_cnt};
    assign access_valid   = valid_q;
    assign access_write   = write_q;
    assign access_data    = data_q;
    assign access_parity  = parity_q;

    genvar g;
    generate
        for (g = 0; g < `LANES; g++) begin : lane
            // Each select covers its data byte and parity bit alike
            assign lane_write_enable[g] = write_q & ~lane_q[g];
        end
    endgenerate
endmodule

// ===== hw/sram_port_controller.sv
// Controller end: drives address, lane selects, strobe, advance and qualify
`timescale 1ns/100ps
`include "sram_port_params.svh"
module sram_port_controller (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    // User request
    input  wire logic                req_valid,
    output logic                     req_ready,
    input  wire logic                req_write,
    input  sram_port_pkg::addr_t     req_address,
    input  wire logic [2:0]          req_length,
    input  sram_port_pkg::lane_sel_t req_lane_enable,
    input  sram_port_pkg::data_t     req_data,
    input  sram_port_pkg::parity_t   req_parity,
    input  wire logic                suspend,
    // Pins to the SRAM
    sram_port_if.controller          pins
);
    import sram_port_pkg::*;

    ctl_state_t state;
    ctl_state_t next_state;
    logic [2:0] remain;
    logic [2:0] next_remain;
    addr_t     addr_q;
    addr_t     next_addr_q;
    lane_sel_t lane_q;
    lane_sel_t next_lane_q;
    logic      we_n_q;
    logic      next_we_n_q;
    logic      adv_q;
    logic      next_adv_q;
    logic      qual_n_q;
    logic      next_qual_n_q;
    data_t     data_q;
    data_t     next_data_q;
    parity_t   parity_q;
    parity_t   next_parity_q;

    // Data beats of a burst reuse the request's payload; no buffering
    assign req_ready = (state == ST_IDLE) && !suspend;

    always_comb begin
        next_state    = state;
        next_remain   = remain;
        next_addr_q   = addr_q;
        next_lane_q   = lane_q;
        next_we_n_q   = we_n_q;
        next_adv_q    = adv_q;
        next_data_q   = data_q;
        next_parity_q = parity_q;
        next_qual_n_q = suspend;
        if (!suspend) begin
            case (state)
                ST_IDLE: begin
                    next_lane_q = `LANES_OFF;
                    next_we_n_q = 1'b1;
                    next_adv_q  = 1'b0;
                    if (req_valid) begin
                        next_addr_q   = req_address;
                        next_adv_q    = 1'b0;
                        next_we_n_q   = ~req_write;
                        next_lane_q   = req_write ? ~req_lane_enable : `LANES_OFF;
                        next_data_q   = req_data;
                        next_parity_q = req_parity;
                        if (req_length > `LEN_ONE) begin
                            next_remain = req_length - `LEN_ONE;
                            next_state  = ST_BURST;
                        end
                    end
                end
                ST_BURST: begin
                    next_adv_q  = 1'b1;
                    next_remain = remain - `LEN_ONE;
                    if (remain == `LEN_ONE) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= ST_IDLE;
            remain   <= `LEN_ZERO;
            addr_q   <= `ADDR_ZERO;
            lane_q   <= `LANES_OFF;
            we_n_q   <= 1'b1;
            adv_q    <= 1'b0;
            qual_n_q <= 1'b1;
            data_q   <= '0;
            parity_q <= '0;
        end else begin
            state    <= next_state;
            remain   <= next_remain;
            addr_q   <= next_addr_q;
            lane_q   <= next_lane_q;
            we_n_q   <= next_we_n_q;
            adv_q    <= next_adv_q;
            qual_n_q <= next_qual_n_q;
            data_q   <= next_data_q;
            parity_q <= next_parity_q;
        end
    end

    assign pins.address             = addr_q;
    assign pins.lane_write_select_n = lane_q;
    assign pins.write_strobe_n      = we_n_q;
    assign pins.advance_or_load     = adv_q;
    assign pins.clock_qualify_n     = qual_n_q;
    assign pins.write_data          = data_q;
    assign pins.parity_lane         = parity_q;
endmodule

// ===== hw/sram_port_if.sv
// Pin-level carrier between the memory controller and the SRAM input port
`timescale 1ns/100ps
interface sram_port_if;
    import sram_port_pkg::*;
    addr_t     address;
    lane_sel_t lane_write_select_n;
    logic      write_strobe_n;
    logic      advance_or_load;
    logic      clock_qualify_n;
    data_t     write_data;
    parity_t   parity_lane;

    modport device (
        input address,
        input lane_write_select_n,
        input write_strobe_n,
        input advance_or_load,
        input clock_qualify_n,
        input write_data,
        input parity_lane
    );
    modport controller (
        output address,
        output lane_write_select_n,
        output write_strobe_n,
        output advance_or_load,
        output clock_qualify_n,
        output write_data,
        output parity_lane
    );
endinterface

// ===== hw/sram_port_params.svh
// Constants for the burst SRAM input port and its controller end
`ifndef SRAM_PORT_PARAMS_SVH
`define SRAM_PORT_PARAMS_SVH
`define ADDR_W        18
`define LANES         4
`define LANE_W        8
`define BURST_W       2
`define BURST_LEN     4
`define ADDR_ZERO     18'h00000
`define BURST_ZERO    2'h0
`define BURST_ONE     2'h1
`define LANES_OFF     4'hf
`define LEN_ZERO      3'h0
`define LEN_ONE       3'h1
`endif

// ===== hw/sram_port_pkg.sv
// Types shared by both ends of the burst SRAM input port
`include "sram_port_params.svh"
package sram_port_pkg;
    typedef logic [`ADDR_W-1:0]         addr_t;
    typedef logic [`LANES-1:0]          lane_sel_t;
    typedef logic [`LANES*`LANE_W-1:0]  data_t;
    typedef logic [`LANES-1:0]          parity_t;
    typedef enum logic [1:0] {ST_IDLE, ST_BURST} ctl_state_t;
endpackage

// ===== verif/sram_port_assertions.sv
// Pin checks between the controller end and the SRAM input port
`timescale 1ns/100ps
module sram_port_assertions (
    // Clock and reset
    input wire logic                ref_clk,
    input wire logic                rst_b,
    // Pins
    input sram_port_pkg::addr_t     address,
    input sram_port_pkg::lane_sel_t lane_write_select_n,
    input wire logic                write_strobe_n,
    input wire logic                advance_or_load,
    input wire logic                clock_qualify_n,
    input sram_port_pkg::data_t     write_data,
    input sram_port_pkg::parity_t   parity_lane
);
    import sram_port_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // A recognised edge that steps the burst counter
    sequence s_step;
        advance_or_load && !clock_qualify_n;
    endsequence
    sequence s_full_run;
        s_step [*3];
    endsequence
    a_step_keeps_kind: assert property (s_step |-> $stable(write_strobe_n))
        else $error("burst changed read or write");
    a_step_keeps_lanes: assert property (s_step |-> $stable(lane_write_select_n))
        else $error("burst changed lane selects");
    a_step_keeps_data: assert property (s_step |-> $stable({parity_lane, write_data}))
        else $error("burst changed payload");
    a_step_keeps_addr: assert property (s_step |-> $stable(address))
        else $error("address moved during advance");
    a_burst_ends_load: assert property (s_full_run |=> !advance_or_load || clock_qualify_n)
        else $error("burst longer than four beats");
    a_freeze_holds_pins: assert property (clock_qualify_n |-> $stable({address, advance_or_load, write_strobe_n}))
        else $error("pins moved on a frozen edge");
endmodule

// ===== verif/testbench.sv
// Self-checking bench: controller and SRAM input port joined pin to pin
`timescale 1ns/100ps
module testbench;
    import sram_port_pkg::*;
    logic        ref_clk, rst_b, req_valid, req_ready, req_write, suspend;
    addr_t       req_address, access_address, held;
    logic        held_write;
    lane_sel_t   held_lanes;
    logic [2:0]  req_length;
    lane_sel_t   req_lane_enable, lane_write_enable;
    data_t       req_data, access_data;
    parity_t     req_parity, access_parity;
    logic        access_valid, access_write;
    logic [31:0] rnd;
    logic [58:0] q_exp[$];
    logic [58:0] e;
    int          q_due[$];
    int          cyc, err_total, check_count, frz;
    sram_port_if pins ();
    sram_port_controller u_sram_port_controller (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_address(req_address), .req_length(req_length),
        .req_lane_enable(req_lane_enable), .req_data(req_data), .req_parity(req_parity),
        .suspend(suspend), .pins(pins));
    sram_input_port u_sram_input_port (.ref_clk(ref_clk), .rst_b(rst_b), .pins(pins),
        .access_address(access_address), .access_valid(access_valid), .access_write(access_write),
        .lane_write_enable(lane_write_enable), .access_data(access_data), .access_parity(access_parity));
    sram_port_assertions u_sram_port_assertions (.ref_clk(ref_clk), .rst_b(rst_b), .address(pins.address),
        .lane_write_select_n(pins.lane_write_select_n), .write_strobe_n(pins.write_strobe_n),
        .advance_or_load(pins.advance_or_load), .clock_qualify_n(pins.clock_qualify_n),
        .write_data(pins.write_data), .parity_lane(pins.parity_lane));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Run is about 610 cycles; allow 2000 cycles, a little over three times that
    initial begin
        #80000;
        err_total++;
        stop_test();
    end
    initial begin
        rst_b = 1'b0; req_valid = 1'b0; req_write = 1'b0; suspend = 1'b0;
        req_address = 18'h00000; req_length = 3'h0; req_lane_enable = 4'h0;
        req_data = 32'h0; req_parity = 4'h0; rnd = 32'h2; frz = -1;
        cyc = 0; err_total = 0; check_count = 0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 600; i++) begin
            @(posedge ref_clk);
            cyc++;
            rnd = lfsr(rnd);
            if (suspend) begin
                suspend <= 1'b0;
            end else if (!(req_valid && !req_ready)) begin
                // Burst beats wrap on the low two address bits and reuse one payload
                if (req_valid) begin
                    for (int k = 0; k < ((req_length < 3'h2) ? 1 : int'(req_length)); k++) begin
                        q_due.push_back(cyc + 1 + k);
                        q_exp.push_back({req_write, req_write ? req_lane_enable : 4'h0, req_parity, req_data,
                            req_address[17:2], 2'(req_address[1:0] + k)});
                    end
                end
                if (!req_valid && cyc > frz && rnd[3:0] == 4'h5) begin
                    // A freeze edge delays by one cycle every beat due two or more cycles from now
                    foreach (q_due[j]) begin
                        if (q_due[j] >= cyc + 2) begin
                            q_due[j]++;
                        end
                    end
                    suspend <= 1'b1;
                    req_valid <= 1'b0;
                    frz = cyc + 2;
                end else begin
                    req_valid <= rnd[0];
                    req_write <= rnd[1];
                    req_length <= 3'(rnd[4:2] % 5);
                    req_lane_enable <= rnd[8:5];
                    req_parity <= rnd[12:9];
                    req_address <= rnd[31:14];
                    req_data <= {rnd[15:0], rnd[31:16]};
                end
            end
            #1;
            if (q_due.size() > 0 && q_due[0] == cyc) begin
                e = q_exp.pop_front();
                void'(q_due.pop_front());
                chk("address", 36'(e[17:0]), 36'(access_address));
                chk("write", 36'(e[58]), 36'(access_write));
                chk("lanes", 36'(e[57:54]), 36'(lane_write_enable));
                if (e[58]) chk("payload", e[53:18], {access_parity, access_data});
                chk("valid", 36'h1, 36'(access_valid));
            end else if (cyc == frz) begin
                chk("frozen address", 36'(held), 36'(access_address));
                chk("frozen write", 36'(held_write), 36'(access_write));
                chk("frozen lanes", 36'(held_lanes), 36'(lane_write_enable));
            end else if (cyc > 1) begin
                chk("idle write", 36'h0, 36'(access_write));
                chk("idle lanes", 36'h0, 36'(lane_write_enable));
            end
            if (cyc == 1) chk("valid after reset", 36'h0, 36'(access_valid));
            held = access_address;
            held_write = access_write;
            held_lanes = lane_write_enable;
        end
        stop_test();
    end
endmodule
